// >>> logic/ebt_defs.vh
`ifndef EBT_DEFS_VH
`define EBT_DEFS_VH

// Special function register addresses
`define EBT_CNT_ADDR 8'hCA
`define EBT_CTL_ADDR 8'hCB
`define EBT_CCTL0_ADDR 8'hCC
`define EBT_CC0_ADDR 8'hCD
`define EBT_CCTL1_ADDR 8'hCE
`define EBT_CC1_ADDR 8'hCF
`define EBT_FLAG_ADDR 8'hD8

// Control register fields
`define EBT_CTL_DIV_HI 7
`define EBT_CTL_DIV_LO 5
`define EBT_CTL_RUN 4
`define EBT_CTL_OVF_MASK 3
`define EBT_CTL_CLR 2
`define EBT_CTL_MODE_HI 1
`define EBT_CTL_MODE_LO 0
`define EBT_CTL_RESET 8'h08
`define EBT_CTL_WMASK 8'hFB

// Channel control fields
`define EBT_CCTL_MASK 6
`define EBT_CCTL_ACT_HI 5
`define EBT_CCTL_ACT_LO 3
`define EBT_CCTL_EN 2
`define EBT_CCTL_RESET 8'h40
`define EBT_CCTL_WMASK 8'h7C

// Shared flag register fields
`define EBT_FLAG_OVF 0
`define EBT_FLAG_CH0 1
`define EBT_FLAG_CH1 2

// Counting modes
`define EBT_MODE_FREE 2'h0
`define EBT_MODE_DOWN 2'h1
`define EBT_MODE_MOD 2'h2
`define EBT_MODE_UPDN 2'h3

// Compare actions
`define EBT_ACT_SET 3'h0
`define EBT_ACT_CLR 3'h1
`define EBT_ACT_TOG 3'h2
`define EBT_ACT_SUPC 3'h3
`define EBT_ACT_CUPS 3'h4
`define EBT_ACT_SETE 3'h5
`define EBT_ACT_CLRE 3'h6

// Counter values and vector numbers
`define EBT_ZERO 8'h00
`define EBT_TOP 8'hFF
`define EBT_VEC_A 4'hB
`define EBT_VEC_B 4'hC

`endif

// >>> logic/ebt_timer.v
// Operation
// RULE_01: Down mode loads period, counts to zero, holds
// RULE_02: Down mode flags terminal count at zero
// RULE_03: Overflow mask gates pending flag and request
// RULE_04: Up/down counts up to period, back down
// RULE_05: Up/down flags terminal count at zero turn
// RULE_06: Enabled channel pin acts on compare match
// RULE_07: Compare pins change only from flip-flops
// RULE_08: Period compare write applies at zero
// RULE_09: Second compare write applies at once
// RULE_10: Channel flag set; masks gate pending, request
// RULE_11: Up/down channel0 flag set at zero turn
// RULE_12: Flags set regardless of mask bits
// RULE_13: Enabling mask on set flag requests again
// RULE_14: One merged interrupt vector per timer instance
// RULE_15: Each channel pulses a DMA trigger on match
// RULE_16: Count register read-only, live, resets zero
// RULE_17: Prescaler divides tick by two to power
// RULE_18: Prescaler changes take effect at once
// RULE_19: Clear bit zeroes counter, always reads zero
// RULE_20: Mode field selects the four count modes
// RULE_21: Software prefers actions three, four for PWM
// RULE_22: Channel1 flag on match; channel0 on match except up/down
// RULE_23: Run bit starts, zero halts and holds
// RULE_24: Free mode wraps after top, flags at top
// RULE_25: Modulo wraps after period, flags at period
// RULE_26: Compare action codes decode as listed
// RULE_27: Halted counter makes no change, no events
`timescale 1ns/100ps
`include "ebt_defs.vh"

module ebt_timer #(
    parameter INSTANCE = 0
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Timer tick from the clock controller
    input wire tick_en,
    // Special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Interrupt controller side
    input wire vector_enable,
    output reg cpu_pending_flag,
    output reg irq_req,
    output reg [3:0] irq_vector,
    // DMA triggers
    output reg dma_trig_0,
    output reg dma_trig_1,
    // Compare pins
    output reg [1:0] cmp_pin_out,
    output reg [1:0] cmp_pin_oe
);

////////////////////////////////////////////////////////////////////////////
// Compare action decode, shared by both channels
////////////////////////////////////////////////////////////////////////////

// Next pin level for one channel at one active edge
function pin_next;
    input [2:0] act;
    input cur;
    input hit;
    input hit_down;
    input at_zero;
    input at_end;
    input at_begin;
    begin
        pin_next = cur;
        case (act)
            `EBT_ACT_SET: begin
                if (hit) pin_next = 1'b1;
            end
            `EBT_ACT_CLR: begin
                if (hit) pin_next = 1'b0;
            end
            `EBT_ACT_TOG: begin
                if (hit) pin_next = ~cur;
            end
            `EBT_ACT_SUPC: begin
                if (at_zero || hit_down) pin_next = 1'b0;
                if (hit && !hit_down) pin_next = 1'b1;
            end
            `EBT_ACT_CUPS: begin
                if (at_zero || hit_down) pin_next = 1'b1;
                if (hit && !hit_down) pin_next = 1'b0;
            end
            `EBT_ACT_SETE: begin
                if (at_end) pin_next = 1'b0;
                if (hit) pin_next = 1'b1;
            end
            `EBT_ACT_CLRE: begin
                if (at_begin) pin_next = 1'b1;
                if (hit) pin_next = 1'b0;
            end
            default: begin
                // Unused code leaves the pin alone
                pin_next = cur;
            end
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Registers and state
////////////////////////////////////////////////////////////////////////////

reg [7:0] cnt_reg; // Live counter
reg [7:0] cnt_next;
reg dir_down_reg; // Up/down direction, 1 while counting down
reg dir_down_next;
reg [7:0] ctl_reg; // Control, clear bit never stored
reg [7:0] cctl0_reg; // Channel 0 control
reg [7:0] cctl1_reg; // Channel 1 control
reg [7:0] cc0_pend_reg; // Period value as written
reg [7:0] cc0_act_reg; // Period value in use
reg [7:0] cc1_reg; // Second compare, used directly
reg [2:0] flag_reg; // Overflow, channel 0, channel 1
reg [6:0] pre_reg; // Prescaler ripple count

wire [2:0] div_sel = ctl_reg[`EBT_CTL_DIV_HI:`EBT_CTL_DIV_LO];
wire [1:0] mode = ctl_reg[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO];
wire running = ctl_reg[`EBT_CTL_RUN];
wire wr_ctl = sfr_wr && (sfr_addr == `EBT_CTL_ADDR);
wire wr_flag = sfr_wr && (sfr_addr == `EBT_FLAG_ADDR);
wire wr_cc0 = sfr_wr && (sfr_addr == `EBT_CC0_ADDR);
wire clr_cmd = wr_ctl && sfr_wdata[`EBT_CTL_CLR];
wire start_cmd = wr_ctl && sfr_wdata[`EBT_CTL_RUN] && !running;
// Mode as written, so one control write can pick down mode and start
wire [1:0] mode_wr = sfr_wdata[`EBT_CTL_MODE_HI:`EBT_CTL_MODE_LO];
wire start_down = start_cmd && (mode_wr == `EBT_MODE_DOWN); // RULE_01

////////////////////////////////////////////////////////////////////////////
// Prescaler
////////////////////////////////////////////////////////////////////////////

// Mask of low prescaler bits that must all be set for an active edge.
// Decoding the live field means a new divider acts on the next tick
// without waiting for the ripple count to wrap.
wire [6:0] pre_mask = ~(7'h7F << div_sel); // RULE_17 RULE_18
wire active = tick_en && ((pre_reg & pre_mask) == pre_mask); // RULE_17
wire step = active && running; // RULE_23 RULE_27

// Ripple count advances on every tick
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        pre_reg <= 7'h00;
    end else if (tick_en) begin
        pre_reg <= pre_reg + 7'h01;
    end
end

////////////////////////////////////////////////////////////////////////////
// Counter next state
////////////////////////////////////////////////////////////////////////////

// Next count and direction for one active edge
always @* begin
    cnt_next = cnt_reg;
    dir_down_next = dir_down_reg;
    case (mode) // RULE_20
        `EBT_MODE_FREE: begin
            // Wrap to zero the edge after the top value
            cnt_next = cnt_reg + 8'h01; // RULE_24
        end
        `EBT_MODE_DOWN: begin
            // Hold once zero is reached
            if (cnt_reg != `EBT_ZERO) begin
                cnt_next = cnt_reg - 8'h01; // RULE_01
            end
        end
        `EBT_MODE_MOD: begin
            if (cnt_reg == cc0_act_reg) begin
                cnt_next = `EBT_ZERO; // RULE_25
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end
        `EBT_MODE_UPDN: begin
            // Turn around at the period and at zero
            if (!dir_down_reg && cnt_reg == cc0_act_reg) begin
                dir_down_next = 1'b1;
            end else if (dir_down_reg && cnt_reg == `EBT_ZERO) begin
                dir_down_next = 1'b0;
            end
            if (dir_down_next) begin
                cnt_next = cnt_reg - 8'h01; // RULE_04
            end else begin
                cnt_next = cnt_reg + 8'h01; // RULE_04
            end
        end
        default: begin
            cnt_next = cnt_reg;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// Events at one active edge
////////////////////////////////////////////////////////////////////////////

wire at_zero = (cnt_next == `EBT_ZERO);
wire hit0 = (cnt_next == cc0_act_reg);
wire hit1 = (cnt_next == cc1_reg);
// Arrival at zero while counting down is the up/down turn point
wire updn_turn = (mode == `EBT_MODE_UPDN) && dir_down_next && at_zero;

// Terminal count event per mode
reg ovf_evt;
always @* begin
    ovf_evt = 1'b0;
    case (mode)
        `EBT_MODE_FREE: ovf_evt = (cnt_next == `EBT_TOP); // RULE_24
        `EBT_MODE_DOWN: ovf_evt = at_zero && (cnt_reg != `EBT_ZERO); // RULE_02
        `EBT_MODE_MOD: ovf_evt = hit0; // RULE_25
        `EBT_MODE_UPDN: ovf_evt = updn_turn; // RULE_05
        default: ovf_evt = 1'b0;
    endcase
end

// Channel 0 flag moves to the zero turn in up/down
wire ch0_evt = (mode == `EBT_MODE_UPDN) ? updn_turn : hit0; // RULE_11
wire ch1_evt = hit1; // RULE_22
wire [2:0] set_evt = step ? {ch1_evt, ch0_evt, ovf_evt} : 3'h0; // RULE_27

////////////////////////////////////////////////////////////////////////////
// Counter, direction and control registers
////////////////////////////////////////////////////////////////////////////

// Clear wins over counting; start in down mode loads the period
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cnt_reg <= `EBT_ZERO; // RULE_16
        dir_down_reg <= 1'b0;
    end else if (clr_cmd) begin
        cnt_reg <= `EBT_ZERO; // RULE_19
        dir_down_reg <= 1'b0;
    end else if (start_down) begin
        cnt_reg <= cc0_act_reg; // RULE_01
    end else if (step) begin
        cnt_reg <= cnt_next;
        dir_down_reg <= dir_down_next;
    end
end

// Control write; the clear bit is a strobe and is never kept
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        ctl_reg <= `EBT_CTL_RESET;
    end else if (wr_ctl) begin
        ctl_reg <= sfr_wdata & `EBT_CTL_WMASK; // RULE_19 RULE_23
    end
end

// Channel controls and the second compare value
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cctl0_reg <= `EBT_CCTL_RESET;
        cctl1_reg <= `EBT_CCTL_RESET;
        cc1_reg <= `EBT_ZERO;
    end else if (sfr_wr) begin
        if (sfr_addr == `EBT_CCTL0_ADDR) begin
            cctl0_reg <= sfr_wdata & `EBT_CCTL_WMASK;
        end
        if (sfr_addr == `EBT_CCTL1_ADDR) begin
            cctl1_reg <= sfr_wdata & `EBT_CCTL_WMASK;
        end
        if (sfr_addr == `EBT_CC1_ADDR) begin
            cc1_reg <= sfr_wdata; // RULE_09
        end
    end
end

// Period value is staged so a period never changes mid-cycle
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cc0_pend_reg <= `EBT_ZERO;
        cc0_act_reg <= `EBT_ZERO;
    end else begin
        if (wr_cc0) begin
            cc0_pend_reg <= sfr_wdata; // RULE_08
        end
        if (cnt_reg == `EBT_ZERO) begin
            cc0_act_reg <= wr_cc0 ? sfr_wdata : cc0_pend_reg; // RULE_08
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Shared flags
////////////////////////////////////////////////////////////////////////////

// Software clears by writing 0; a new event in the same cycle wins
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        flag_reg <= 3'h0;
    end else begin
        flag_reg <= (wr_flag ? (flag_reg & sfr_wdata[2:0]) : flag_reg)
            | set_evt; // RULE_12
    end
end

////////////////////////////////////////////////////////////////////////////
// Compare pins and DMA triggers
////////////////////////////////////////////////////////////////////////////

wire [2:0] act0 = cctl0_reg[`EBT_CCTL_ACT_HI:`EBT_CCTL_ACT_LO];
wire [2:0] act1 = cctl1_reg[`EBT_CCTL_ACT_HI:`EBT_CCTL_ACT_LO];
wire [1:0] ch_en = {cctl1_reg[`EBT_CCTL_EN], cctl0_reg[`EBT_CCTL_EN]};
wire [1:0] hit = {hit1, hit0};
wire down_now = (mode == `EBT_MODE_UPDN) && dir_down_next;

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
        wire [2:0] act = (gi == 0) ? act0 : act1;
        // Channel 0 ends at the top, channel 1 at the period
        wire at_end = (gi == 0) ? (cnt_next == `EBT_TOP) : hit0;
        wire at_begin = (gi == 0) ? at_zero : hit0;
        // Pins are flip-flop outputs so no decode glitch reaches them
        always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                cmp_pin_out[gi] <= 1'b0;
                cmp_pin_oe[gi] <= 1'b0;
            end else begin
                cmp_pin_oe[gi] <= ch_en[gi]; // RULE_06
                if (step && ch_en[gi]) begin
                    cmp_pin_out[gi] <= pin_next(act, cmp_pin_out[gi],
                        hit[gi], hit[gi] && down_now, at_zero,
                        at_end, at_begin); // RULE_06 RULE_07 RULE_26
                end
            end
        end
    end
endgenerate

// One-cycle trigger on each channel compare
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        dma_trig_0 <= 1'b0;
        dma_trig_1 <= 1'b0;
    end else begin
        dma_trig_0 <= step && hit0; // RULE_15
        dma_trig_1 <= step && hit1; // RULE_15
    end
end

////////////////////////////////////////////////////////////////////////////
// Interrupt request
////////////////////////////////////////////////////////////////////////////

// Level form: raising a mask over a set flag requests again
wire [2:0] irq_mask = {cctl1_reg[`EBT_CCTL_MASK], cctl0_reg[`EBT_CCTL_MASK],
    ctl_reg[`EBT_CTL_OVF_MASK]};
wire pending = |(flag_reg & irq_mask); // RULE_03 RULE_10 RULE_13

// All sources merge onto this instance's single vector
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cpu_pending_flag <= 1'b0;
        irq_req <= 1'b0;
        irq_vector <= `EBT_VEC_A;
    end else begin
        cpu_pending_flag <= pending; // RULE_03 RULE_10
        irq_req <= pending && vector_enable; // RULE_03 RULE_10 RULE_14
        irq_vector <= (INSTANCE == 0) ? `EBT_VEC_A : `EBT_VEC_B; // RULE_14
    end
end

////////////////////////////////////////////////////////////////////////////
// Register read
////////////////////////////////////////////////////////////////////////////

// Read data registered on the read strobe; unmapped reads return zero
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
        case (sfr_addr)
            `EBT_CNT_ADDR: sfr_rdata <= cnt_reg; // RULE_16
            `EBT_CTL_ADDR: sfr_rdata <= ctl_reg; // RULE_19
            `EBT_CCTL0_ADDR: sfr_rdata <= cctl0_reg;
            `EBT_CC0_ADDR: sfr_rdata <= cc0_pend_reg;
            `EBT_CCTL1_ADDR: sfr_rdata <= cctl1_reg;
            `EBT_CC1_ADDR: sfr_rdata <= cc1_reg;
            `EBT_FLAG_ADDR: sfr_rdata <= {5'h00, flag_reg};
            default: sfr_rdata <= 8'h00;
        endcase
    end
end

endmodule // ebt_timer

// >>> tb/ebt_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Far side: tick source, interrupt controller and DMA trigger counter
module ebt_host_model (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Interrupt controller
    input wire irq_on,
    output reg vector_enable,
    // Tick source
    output reg tick_en,
    // DMA controller
    input wire dma_trig_0,
    input wire dma_trig_1,
    output reg [7:0] dma_seen_0,
    output reg [7:0] dma_seen_1
);
    // Tick on every second cycle so each pulse stands alone
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_en <= 1'h0;
            vector_enable <= 1'h0;
            dma_seen_0 <= 8'h00;
            dma_seen_1 <= 8'h00;
        end else begin
            tick_en <= ~tick_en;
            // Enable is a level the CPU sets, seen one edge later
            vector_enable <= irq_on;
            // Each trigger pulse counts as one DMA request
            dma_seen_0 <= dma_seen_0 + {7'h00, dma_trig_0};
            dma_seen_1 <= dma_seen_1 + {7'h00, dma_trig_1};
        end
    end
endmodule // ebt_host_model

// >>> tb/ebt_timer_asserts.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Port-level checks on the compare timer
module ebt_timer_asserts #(
    parameter INSTANCE = 0
) (
    input wire clk_sys,
    input wire rst,
    input wire tick_en,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire vector_enable,
    input wire cpu_pending_flag,
    input wire irq_req,
    input wire [3:0] irq_vector,
    input wire dma_trig_0,
    input wire dma_trig_1,
    input wire [1:0] cmp_pin_out,
    input wire [1:0] cmp_pin_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_irq_gated: assert property (
        irq_req |-> $past(vector_enable)) else $error("irq without enable");
    a_vector_id: assert property (
        irq_vector == (INSTANCE == 0 ? 4'hB : 4'hC))
        else $error("wrong vector");
    a_dma0_pulse: assert property (
        dma_trig_0 |-> $past(tick_en) ##1 !dma_trig_0)
        else $error("dma0 not a tick pulse");
    a_dma1_pulse: assert property (
        dma_trig_1 |-> $past(tick_en) ##1 !dma_trig_1)
        else $error("dma1 not a tick pulse");
    // Pins only move on an active edge, so no stray edges
    a_pin_on_tick: assert property (
        !$stable(cmp_pin_out) |-> $past(tick_en))
        else $error("pin moved off tick");
    // Enable lands in the channel register, then in the pin a cycle later
    a_oe_by_write: assert property (
        !$stable(cmp_pin_oe) |->
        $past(sfr_wr, 2) && ($past(sfr_addr, 2) inside {8'hCC, 8'hCE}))
        else $error("oe moved without write");
    a_clr_reads_0: assert property (
        sfr_rd && sfr_addr == 8'hCB |=> !sfr_rdata[2])
        else $error("clear bit read 1");
    a_pend_cause: assert property (
        $rose(cpu_pending_flag) |-> $past(tick_en, 2) || $past(sfr_wr, 2))
        else $error("pending without cause");
endmodule // ebt_timer_asserts

// >>> tb/ebt_timer_test.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module ebt_timer_test;
    // Bench-driven inputs
    reg clk_sys = 1'h0;
    reg rst = 1'h1;
    reg [7:0] sfr_addr = 8'h00;
    reg sfr_wr = 1'h0;
    reg sfr_rd = 1'h0;
    reg [7:0] sfr_wdata = 8'h00;
    reg irq_on = 1'h0;
    // Observed outputs
    wire [7:0] sfr_rdata, dma_seen_0, dma_seen_1;
    wire tick_en, vector_enable, cpu_pending_flag, irq_req;
    wire dma_trig_0, dma_trig_1;
    wire [3:0] irq_vector;
    wire [1:0] cmp_pin_out, cmp_pin_oe;
    int num_errors = 0;
    int comparisons = 0;
    reg [7:0] rv, mx, mn;
    always #2.5 clk_sys = ~clk_sys;
    ebt_timer dut (.clk_sys(clk_sys), .rst(rst), .tick_en(tick_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .vector_enable(vector_enable), .cpu_pending_flag(cpu_pending_flag),
        .irq_req(irq_req), .irq_vector(irq_vector), .dma_trig_0(dma_trig_0),
        .dma_trig_1(dma_trig_1), .cmp_pin_out(cmp_pin_out),
        .cmp_pin_oe(cmp_pin_oe));
    ebt_host_model host (.clk_sys(clk_sys), .rst(rst), .irq_on(irq_on),
        .vector_enable(vector_enable), .tick_en(tick_en),
        .dma_trig_0(dma_trig_0), .dma_trig_1(dma_trig_1),
        .dma_seen_0(dma_seen_0), .dma_seen_1(dma_seen_1));
    ////////////////////////////////////////////////////////////////////
    // Bus helpers; all start and end 1 ns after a rising edge
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Strobe drops for a cycle so it is never set twice in a step
    task wr(input [7:0] a, input [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        cyc(1);
        sfr_wr = 1'h0;
        cyc(1);
    endtask
    task rd(input [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'h1;
        cyc(1);
        rv = sfr_rdata;
        sfr_rd = 1'h0;
        cyc(1);
    endtask
    task chk(input [7:0] g, input [7:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Reads land once per tick, so no count value is missed
    task wait_cnt(input [7:0] v);
        int i;
        i = 0;
        rd(8'hCA);
        while (rv !== v && i < 3000) begin
            rd(8'hCA);
            i++;
        end
        chk(rv, v, "count target");
    endtask
    task span(input int n);
        mx = 8'h00;
        mn = 8'hFF;
        repeat (n) begin
            rd(8'hCA);
            if (rv > mx) mx = rv;
            if (rv < mn) mn = rv;
        end
    endtask
    task restart(input [7:0] ctl, input [7:0] cc0);
        wr(8'hCB, 8'h04);
        wr(8'hD8, 8'h00);
        wr(8'hCD, cc0);
        wr(8'hCB, ctl);
    endtask
    task give_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Reset values, read-only count, unmapped place
    task t_reset;
        rd(8'hCA); chk(rv, 8'h00, "count reset");
        rd(8'hCB); chk(rv, 8'h08, "ctl reset");
        wr(8'hCA, 8'h5A);
        rd(8'hCA); chk(rv, 8'h00, "count write");
        rd(8'h10); chk(rv, 8'h00, "unmapped");
        chk({4'h0, irq_vector}, 8'h0B, "vector");
    endtask
    // Every divider code; interval in 10 ns tick periods
    // Clear with each code, else slow codes need a full wrap first
    task t_presc;
        time t1;
        for (int d = 0; d < 8; d++) begin
            wr(8'hCB, {d[2:0], 5'h14});
            wait_cnt(8'h10);
            t1 = $time;
            wait_cnt(8'h11);
            chk(8'(($time - t1) / 10), 8'(1 << d), "divider");
        end
    endtask
    // Free-running wrap, flag, masks and request
    task t_free;
        wr(8'hCC, 8'h00);
        wr(8'hCE, 8'h00);
        restart(8'h18, 8'h00);
        wait_cnt(8'hFF);
        rd(8'hCA); chk(rv, 8'h00, "wrap");
        rd(8'hD8); chk(rv & 8'h01, 8'h01, "ovf flag");
        chk({7'h0, cpu_pending_flag}, 8'h01, "pending");
        chk({7'h0, irq_req}, 8'h00, "irq off");
        irq_on = 1'h1;
        cyc(3);
        chk({7'h0, irq_req}, 8'h01, "irq on");
        wr(8'hCB, 8'h10);
        cyc(2);
        chk({7'h0, cpu_pending_flag}, 8'h00, "masked");
        wr(8'hCB, 8'h18);
        cyc(2);
        chk({7'h0, irq_req}, 8'h01, "remask irq");
        wr(8'hCB, 8'h10);
        wr(8'hD8, 8'h00);
        wait_cnt(8'h02);
        rd(8'hD8); chk(rv & 8'h01, 8'h01, "flag unmasked");
        chk({7'h0, cpu_pending_flag}, 8'h00, "no pend");
        irq_on = 1'h0;
    endtask
    // Halt holds, clear zeroes and reads back 0
    task t_halt;
        wr(8'hCB, 8'h00);
        rd(8'hCA);
        mx = rv;
        cyc(50);
        rd(8'hCA); chk(rv, mx, "halt");
        wr(8'hCB, 8'h04);
        rd(8'hCA); chk(rv, 8'h00, "clear");
        rd(8'hCB); chk(rv, 8'h00, "clear reads");
    endtask
    // Down, up/down and modulo modes
    task t_modes;
        restart(8'h11, 8'h09);
        wait_cnt(8'h00);
        cyc(20);
        rd(8'hCA); chk(rv, 8'h00, "down hold");
        rd(8'hD8); chk(rv & 8'h01, 8'h01, "down flag");
        restart(8'h13, 8'h06);
        span(40);
        chk(mx, 8'h06, "updn top");
        chk(mn, 8'h00, "updn bottom");
        rd(8'hD8); chk(rv & 8'h03, 8'h03, "turn flags");
        // Climb to the period with flags clear: no channel 0 flag at top
        wait_cnt(8'h00);
        wr(8'hD8, 8'h00);
        wait_cnt(8'h06);
        rd(8'hD8); chk(rv & 8'h03, 8'h00, "no ch0 at top");
        wr(8'hCD, 8'h03);
        wait_cnt(8'h00);
        span(30);
        chk(mx, 8'h03, "cc0 at zero");
        restart(8'h12, 8'h0A);
        span(40);
        chk(mx, 8'h0A, "modulo top");
        rd(8'hD8); chk(rv & 8'h01, 8'h01, "mod flag");
    endtask
    // Channel 1 actions, pin, flag, DMA and mask
    task t_cmp;
        restart(8'h04, 8'h0A);
        wr(8'hCF, 8'h20);
        wr(8'hCE, 8'h44);
        chk({6'h0, cmp_pin_oe}, 8'h02, "oe");
        mx = dma_seen_1;
        mn = dma_seen_0;
        wr(8'hCB, 8'h10);
        wait_cnt(8'h30);
        chk({6'h0, cmp_pin_out}, 8'h02, "set");
        chk(dma_seen_1 - mx, 8'h01, "dma1");
        chk(dma_seen_0 - mn, 8'h01, "dma0");
        rd(8'hD8); chk(rv & 8'h04, 8'h04, "ch1 flag");
        chk({7'h0, cpu_pending_flag}, 8'h01, "ch pend");
        wr(8'hCE, 8'h4C);
        wait_cnt(8'h10);
        wait_cnt(8'h30);
        chk({6'h0, cmp_pin_out}, 8'h00, "clear");
        wr(8'hCE, 8'h54);
        wait_cnt(8'h10);
        wait_cnt(8'h30);
        chk({6'h0, cmp_pin_out}, 8'h02, "toggle");
        wr(8'hCE, 8'h5C);
        wait_cnt(8'h00);
        wait_cnt(8'h10);
        chk({6'h0, cmp_pin_out}, 8'h00, "pwm low");
        wait_cnt(8'h40);
        chk({6'h0, cmp_pin_out}, 8'h02, "pwm high");
        wr(8'hCE, 8'h00);
        chk({6'h0, cmp_pin_oe}, 8'h00, "oe off");
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        t_reset;
        t_presc;
        t_free;
        t_halt;
        t_modes;
        t_cmp;
        give_verdict;
    end
    // Watchdog well beyond the expected run
    initial begin
        #400000;
        num_errors++;
        give_verdict;
    end
endmodule // ebt_timer_test
bind ebt_timer ebt_timer_asserts #(.INSTANCE(INSTANCE)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .tick_en(tick_en), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .vector_enable(vector_enable),
    .cpu_pending_flag(cpu_pending_flag), .irq_req(irq_req),
    .irq_vector(irq_vector), .dma_trig_0(dma_trig_0),
    .dma_trig_1(dma_trig_1), .cmp_pin_out(cmp_pin_out),
    .cmp_pin_oe(cmp_pin_oe));
